// ==== hdl/mdsr_driver_status.v ====
// motor driver status word with apb access, latched fault flags and interrupt
`default_nettype none
`include "mdsr_defs.vh"

module mdsr_driver_status (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // live sources from the driver core
    input wire stepPulse,
    input wire openLoadPhaseD,
    input wire openLoadPhaseSecond,
    input wire groundShortPhaseD,
    input wire groundShortPhaseC,
    input wire supplyShortPhaseD,
    input wire supplyShortPhaseC,
    input wire thermalPrewarn,
    input wire thermalShutdown,
    input wire [9:0] loadMeasureValue,
    input wire [9:0] coilAOnTime,
    input wire [4:0] currentScaleActual,
    input wire fullStepActive,
    input wire quietChopperActive,
    // outputs to bridges and system
    output reg driverDisable,
    output reg standstill,
    output reg irq
);

    reg gsdR_r;
    reg gscR_r;
    reg ssdR_r;
    reg sscR_r;
    reg otLatch_r;
    reg stst_r;
    reg [`MDSR_TMR_W-1:0] tmr_r;
    reg [3:0] offTime_r;
    reg swDisable_r;
    reg [2:0] tmrSel_r;
    reg [`MDSR_IRQ_W-1:0] irqStat_r;
    reg [`MDSR_IRQ_W-1:0] irqMask_r;
    reg [31:0] statusWord;
    reg [31:0] rdNxt;
    reg [`MDSR_IRQ_W-1:0] events;
    reg [`MDSR_IRQ_W-1:0] irqStat_nxt;
    reg [`MDSR_TMR_W-1:0] tmrLimit;
    reg stallPrev_r;
    reg otPrev_r;

    wire swOff = (offTime_r == `MDSR_CHOPPER_OFF_TIME_SETTING_RST) || swDisable_r;
    wire [7:0] addr = paddr[`MDSR_ADDR_W-1:0];
    wire acc = psel && penable && !pready;
    wire wrAcc = acc && pwrite;
    wire stallNow = (loadMeasureValue == 10'h000);
    wire [4:0] tmrExp = `MDSR_STST_MIN_EXP + {2'b00, tmrSel_r};

    // latched short flags: software disable clears, a new short while enabled wins
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gsdR_r <= 1'b0;
            gscR_r <= 1'b0;
            ssdR_r <= 1'b0;
            sscR_r <= 1'b0;
        end
        else if (swOff)
        begin
            gsdR_r <= 1'b0;
            gscR_r <= 1'b0;
            ssdR_r <= 1'b0;
            sscR_r <= 1'b0;
        end
        else
        begin
            gsdR_r <= gsdR_r | groundShortPhaseD;
            gscR_r <= gscR_r | groundShortPhaseC;
            ssdR_r <= ssdR_r | supplyShortPhaseD;
            sscR_r <= sscR_r | supplyShortPhaseC;
        end
    end

    // shutdown holds until both shutdown and prewarning have gone away
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            otLatch_r <= 1'b0;
        else if (thermalShutdown)
            otLatch_r <= 1'b1;
        else if (!thermalPrewarn)
            otLatch_r <= 1'b0;
    end

    // standstill timer restarts on each step pulse
    always @*
    begin
        tmrLimit = {`MDSR_TMR_W{1'b0}};
        tmrLimit[tmrExp] = 1'b1;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmr_r <= {`MDSR_TMR_W{1'b0}};
            stst_r <= 1'b0;
        end
        else if (stepPulse)
        begin
            tmr_r <= {`MDSR_TMR_W{1'b0}};
            stst_r <= 1'b0;
        end
        else if (tmr_r >= tmrLimit - 1'b1)
            stst_r <= 1'b1;
        else
            tmr_r <= tmr_r + 1'b1;
    end

    // open-load bits are pass-through only and never feed driverDisable
    always @*
    begin
        statusWord = 32'h0000_0000;
        statusWord[`MDSR_B_STST] = stst_r;
        statusWord[`MDSR_B_OLD] = openLoadPhaseD;
        statusWord[`MDSR_B_OLC] = openLoadPhaseSecond;
        statusWord[`MDSR_B_GSD] = gsdR_r;
        statusWord[`MDSR_B_GSC] = gscR_r;
        statusWord[`MDSR_B_OTPW] = thermalPrewarn;
        // live shutdown is ored in so the flag shows in the very cycle it is reached
        statusWord[`MDSR_B_OT] = otLatch_r | thermalShutdown;
        statusWord[`MDSR_B_STALL] = stallNow;
        statusWord[`MDSR_CS_HI:`MDSR_CS_LO] = currentScaleActual;
        statusWord[`MDSR_B_FS] = fullStepActive;
        statusWord[`MDSR_B_QUIET] = quietChopperActive;
        statusWord[`MDSR_B_SSD] = ssdR_r;
        statusWord[`MDSR_B_SSC] = sscR_r;
        statusWord[`MDSR_LV_HI:`MDSR_LV_LO] = stst_r ? coilAOnTime : loadMeasureValue;
    end

    // interrupt events: live short levels while enabled, rising edges of shutdown and stall
    always @*
    begin
        events = {`MDSR_IRQ_W{1'b0}};
        events[`MDSR_I_GSD] = groundShortPhaseD && !swOff;
        events[`MDSR_I_GSC] = groundShortPhaseC && !swOff;
        events[`MDSR_I_SSD] = supplyShortPhaseD && !swOff;
        events[`MDSR_I_SSC] = supplyShortPhaseC && !swOff;
        events[`MDSR_I_OT] = thermalShutdown && !otPrev_r;
        events[`MDSR_I_STALL] = stallNow && !stallPrev_r;
        irqStat_nxt = irqStat_r;
        if (wrAcc && addr == `MDSR_OFF_IRQ_STAT && pstrb[0])
            irqStat_nxt = irqStat_r & ~pwdata[`MDSR_IRQ_W-1:0];
        // a new event in the clearing cycle survives
        irqStat_nxt = irqStat_nxt | events;
    end

    // read mux; status word ignores writes
    always @*
    begin
        rdNxt = 32'h0000_0000;
        case (addr)
            `MDSR_OFF_STATUS: rdNxt = statusWord;
            `MDSR_OFF_CTRL:
            begin
                rdNxt[`MDSR_CHOPPER_OFF_TIME_SETTING_HI:`MDSR_CHOPPER_OFF_TIME_SETTING_LO] = offTime_r;
                rdNxt[`MDSR_C_DIS] = swDisable_r;
                rdNxt[`MDSR_TSEL_HI:`MDSR_TSEL_LO] = tmrSel_r;
            end
            `MDSR_OFF_IRQ_STAT: rdNxt[`MDSR_IRQ_W-1:0] = irqStat_r;
            `MDSR_OFF_IRQ_MASK: rdNxt[`MDSR_IRQ_W-1:0] = irqMask_r;
            default: rdNxt = 32'h0000_0000;
        endcase
    end

    wire mapped = (addr == `MDSR_OFF_STATUS) || (addr == `MDSR_OFF_CTRL) ||
        (addr == `MDSR_OFF_IRQ_STAT) || (addr == `MDSR_OFF_IRQ_MASK);
    wire addrOk = mapped && (paddr[31:`MDSR_ADDR_W] == 24'h000000);

    // apb slave: one wait state, answer registered
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            offTime_r <= `MDSR_CHOPPER_OFF_TIME_SETTING_RST;
            swDisable_r <= 1'b0;
            tmrSel_r <= `MDSR_TSEL_RST;
            irqMask_r <= {`MDSR_IRQ_W{1'b0}};
            irqStat_r <= {`MDSR_IRQ_W{1'b0}};
            irq <= 1'b0;
            driverDisable <= 1'b0;
            standstill <= 1'b0;
            stallPrev_r <= 1'b0;
            otPrev_r <= 1'b0;
        end
        else
        begin
            pready <= acc;
            pslverr <= acc && (!addrOk || (pwrite && addr == `MDSR_OFF_STATUS));
            prdata <= (acc && !pwrite && addrOk) ? rdNxt : 32'h0000_0000;
            if (wrAcc && addrOk && addr == `MDSR_OFF_CTRL)
            begin
                if (pstrb[0])
                begin
                    offTime_r <= pwdata[`MDSR_CHOPPER_OFF_TIME_SETTING_HI:`MDSR_CHOPPER_OFF_TIME_SETTING_LO];
                    swDisable_r <= pwdata[`MDSR_C_DIS];
                end
                if (pstrb[1])
                    tmrSel_r <= pwdata[`MDSR_TSEL_HI:`MDSR_TSEL_LO];
            end
            if (wrAcc && addrOk && addr == `MDSR_OFF_IRQ_MASK && pstrb[0])
                irqMask_r <= pwdata[`MDSR_IRQ_W-1:0];
            irqStat_r <= irqStat_nxt;
            irq <= |(irqStat_nxt & irqMask_r);
            driverDisable <= swOff | gsdR_r | gscR_r | ssdR_r | sscR_r | otLatch_r |
                thermalShutdown;
            standstill <= stst_r;
            stallPrev_r <= stallNow;
            otPrev_r <= thermalShutdown;
        end
    end

endmodule
`default_nettype wire

// ==== common/mdsr_defs.vh ====
// constants and register layout of the motor driver status register block
`ifndef MDSR_DEFS_VH
`define MDSR_DEFS_VH

// register byte offsets
`define MDSR_ADDR_W 8
`define MDSR_OFF_STATUS 8'h70
`define MDSR_OFF_CTRL 8'h74
`define MDSR_OFF_IRQ_STAT 8'h78
`define MDSR_OFF_IRQ_MASK 8'h7C

// status field positions
`define MDSR_B_STST 31
`define MDSR_B_OLD 30
`define MDSR_B_OLC 29
`define MDSR_B_GSD 28
`define MDSR_B_GSC 27
`define MDSR_B_OTPW 26
`define MDSR_B_OT 25
`define MDSR_B_STALL 24
`define MDSR_CS_HI 20
`define MDSR_CS_LO 16
`define MDSR_B_FS 15
`define MDSR_B_QUIET 14
`define MDSR_B_SSD 13
`define MDSR_B_SSC 12
`define MDSR_LV_HI 9
`define MDSR_LV_LO 0

// control register fields
`define MDSR_CHOPPER_OFF_TIME_SETTING_HI 3
`define MDSR_CHOPPER_OFF_TIME_SETTING_LO 0
`define MDSR_C_DIS 4
`define MDSR_TSEL_HI 10
`define MDSR_TSEL_LO 8

// interrupt event bits
`define MDSR_IRQ_W 6
`define MDSR_I_GSD 0
`define MDSR_I_GSC 1
`define MDSR_I_SSD 2
`define MDSR_I_SSC 3
`define MDSR_I_OT 4
`define MDSR_I_STALL 5

// standstill timer: length is 2^(13 + select), select 0..7
`define MDSR_STST_MIN_EXP 5'h0D
`define MDSR_STST_MAX_EXP 5'h14
`define MDSR_TMR_W 21
`define MDSR_CHOPPER_OFF_TIME_SETTING_RST 4'h0
`define MDSR_TSEL_RST 3'h0

`endif

// ==== verification/mdsr_driver_status_asserts.sv ====
// concurrent checks on the status block ports
`default_nettype none
module mdsr_driver_status_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // live sources and driver state
    input wire logic thermalPrewarn,
    input wire logic thermalShutdown,
    input wire logic [9:0] loadMeasureValue,
    input wire logic [4:0] currentScaleActual,
    input wire logic driverDisable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence sAccess;
        psel && penable && !pready;
    endsequence
    sequence sStatRead;
        pready && !pwrite && paddr == 32'h70;
    endsequence
    answer_in_time_a: assert property (sAccess |=> pready)
        else $error("no answer after access");
    answer_pulse_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    write_refused_a: assert property (sAccess ##0 (pwrite && paddr == 32'h70) |=> pslverr)
        else $error("status write not refused");
    unused_zero_a: assert property (sStatRead |-> prdata[23:21] == 3'h0 && prdata[11:10] == 2'h0)
        else $error("unused bits set");
    stall_flag_a: assert property (sStatRead |-> prdata[24] == ($past(loadMeasureValue) == 10'h000))
        else $error("stall flag wrong");
    prewarn_live_a: assert property (sStatRead |-> prdata[26] == $past(thermalPrewarn))
        else $error("prewarning not live");
    scale_live_a: assert property (sStatRead |-> prdata[20:16] == $past(currentScaleActual))
        else $error("current scale not live");
    shutdown_off_a: assert property (thermalShutdown |=> driverDisable)
        else $error("driver on in shutdown");
    shutdown_flag_a: assert property (sStatRead ##0 $past(thermalShutdown) |-> prdata[25])
        else $error("shutdown flag missing");
endmodule
bind mdsr_driver_status mdsr_driver_status_asserts u_chk (.*);
`default_nettype wire

// ==== verification/mdsr_core_model.sv ====
// driver core model: step source and bridge short detectors
`default_nettype none
module mdsr_core_model (
    // clock, bench controls and driverDisable from the status block
    input wire logic ref_clk,
    input wire logic moving,
    input wire logic [3:0] fault,
    input wire logic driverDisable,
    // to the status block
    output logic stepPulse,
    output logic groundShortPhaseD,
    output logic groundShortPhaseC,
    output logic supplyShortPhaseD,
    output logic supplyShortPhaseC
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stepCnt_r = 4'h0;
    always @(posedge ref_clk)
    begin
        stepCnt_r <= stepCnt_r + 4'h1;
    end
    assign stepPulse = moving && stepCnt_r == 4'h0;
    // an off bridge carries no current, so no short is sensed
    assign groundShortPhaseD = fault[0] & ~driverDisable;
    assign groundShortPhaseC = fault[1] & ~driverDisable;
    assign supplyShortPhaseD = fault[2] & ~driverDisable;
    assign supplyShortPhaseC = fault[3] & ~driverDisable;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the status block
`default_nettype none
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin nErrors++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic [3:0] pstrb, fault;
    logic stepPulse, groundShortPhaseD, groundShortPhaseC, supplyShortPhaseD;
    logic supplyShortPhaseC, openLoadPhaseD, openLoadPhaseSecond, thermalPrewarn;
    logic thermalShutdown, fullStepActive, quietChopperActive, moving, rerr;
    logic driverDisable, standstill, irq;
    logic [9:0] loadMeasureValue, coilAOnTime;
    logic [4:0] currentScaleActual;
    int nErrors = 0, checkCount = 0, cycles = 0;
    mdsr_driver_status u_dut (.*);
    mdsr_core_model u_core (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic summarize();
        $display("errors %0d checks %0d", nErrors, checkCount);
        if (nErrors == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            nErrors++;
            summarize();
        end
    end
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        `CHK(pready, 1'b1)
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // lat holds {shutdown, supply C, supply D, ground C, ground D}
    // live inputs are read after the access, so values set just before the call count
    task automatic rdst(input logic [4:0] lat, input logic sst);
        apb(1'b0, 32'h70, 32'h0);
        `CHK(rdata, {sst, openLoadPhaseD, openLoadPhaseSecond, lat[0], lat[1], thermalPrewarn,
            lat[4], loadMeasureValue == 10'h000, 3'h0, currentScaleActual, fullStepActive,
            quietChopperActive, lat[2], lat[3], 2'h0, sst ? coilAOnTime : loadMeasureValue})
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, fault} = '0;
        {openLoadPhaseD, openLoadPhaseSecond, thermalPrewarn, thermalShutdown} = 4'h0;
        {fullStepActive, quietChopperActive, currentScaleActual} = 7'h00;
        pstrb = 4'hF;
        moving = 1'b1;
        loadMeasureValue = 10'h155;
        coilAOnTime = 10'h2AA;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdst(5'h00, 1'b0);
        apb(1'b1, 32'h70, 32'hFFFFFFFF);
        `CHK(rerr, 1'b1)
        rdst(5'h00, 1'b0);
        apb(1'b0, 32'h80, 32'h0);
        `CHK({rerr, rdata}, {1'b1, 32'h0})
        {openLoadPhaseD, openLoadPhaseSecond, thermalPrewarn} <= 3'h7;
        {fullStepActive, quietChopperActive, currentScaleActual} <= 7'h7F;
        loadMeasureValue <= 10'h000;
        rdst(5'h00, 1'b0);
        {openLoadPhaseD, openLoadPhaseSecond, thermalPrewarn} <= 3'h0;
        {fullStepActive, quietChopperActive, currentScaleActual} <= 7'h00;
        loadMeasureValue <= 10'h3FF;
        rdst(5'h00, 1'b0);
        apb(1'b1, 32'h74, 32'h1);
        apb(1'b1, 32'h7C, 32'h3E);
        apb(1'b1, 32'h78, 32'h3F);
        `CHK(driverDisable, 1'b0)
        for (int i = 0; i < 4; i++)
        begin
            fault <= 4'h1 << i;
            repeat (3) @(posedge ref_clk);
            fault <= 4'h0;
            rdst(5'h01 << i, 1'b0);
            `CHK({driverDisable, irq}, {1'b1, i != 0})
            apb(1'b1, 32'h78, 32'h3F);
            apb(1'b1, 32'h74, 32'h0);
            apb(1'b1, 32'h74, 32'h1);
            rdst(5'h00, 1'b0);
            `CHK({driverDisable, irq}, 2'h0)
        end
        {thermalPrewarn, thermalShutdown} <= 2'h3;
        repeat (3) @(posedge ref_clk);
        rdst(5'h10, 1'b0);
        thermalShutdown <= 1'b0;
        rdst(5'h10, 1'b0);
        `CHK(driverDisable, 1'b1)
        thermalPrewarn <= 1'b0;
        rdst(5'h00, 1'b0);
        `CHK(driverDisable, 1'b0)
        moving <= 1'b0;
        repeat (8150) @(posedge ref_clk);
        rdst(5'h00, 1'b0);
        repeat (60) @(posedge ref_clk);
        rdst(5'h00, 1'b1);
        `CHK(standstill, 1'b1)
        moving <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rdst(5'h00, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
